// File: bench/msc_remote_model.sv
// Purpose: Far-side model of the modem line and the remote service user.
// Assumes: The bench calls its task 1 ns after a rising edge.
// Notes: Each panic call phase ends after a settable delay, so prompt and slow lines are both covered.
`default_nettype none
module msc_remote_model (
  input  wire logic       i_clk,       // System clock.
  input  wire logic       i_in_panic,  // Card is running a panic call.
  output var  logic       o_call_step, // Call phase finished pulse.
  output var  logic       o_rx_valid,  // Remote character strobe.
  output var  logic [7:0] o_rx_char    // Remote character.
);
  timeunit 1ns;
  timeprecision 100ps;
  int unsigned delay = 0; // Cycles the line needs per phase; zero answers at once.
  int unsigned cnt   = 0; // Cycles spent in the current phase.
  // Lines start quiet so the card sees no stray strobe at time zero.
  initial begin
    o_call_step = 1'b0;
    o_rx_valid  = 1'b0;
    o_rx_char   = 8'h00;
  end
  // One step pulse per phase; the pulse itself restarts the count so no phase is skipped.
  always @(posedge i_clk) begin
    o_call_step <= 1'b0;
    if (!i_in_panic || o_call_step) begin
      cnt <= 0;
    end else if (cnt >= delay) begin
      o_call_step <= 1'b1;
    end else begin
      cnt <= cnt + 1;
    end
  end
  // The character line shows the inverse of the last one once the strobe drops.
  // One edge passes first, so back-to-back calls never drop and raise the strobe in one step.
  task automatic send_char(input logic [7:0] c);
    @(posedge i_clk);
    #1;
    o_rx_char  = c;
    o_rx_valid = 1'b1;
    @(posedge i_clk);
    #1;
    o_rx_valid = 1'b0;
    o_rx_char  = ~c;
  endtask : send_char
endmodule : msc_remote_model
`default_nettype wire

// File: bench/tb_maintenance_state_controller.sv
// Purpose: Self-checking bench for the maintenance card state controller.
// Assumes: 100 MHz clock; every input but i_call_step changes 1 ns after a rising edge.
// Notes: Switch hold count is cut to 20 cycles so the long press stays short.
`default_nettype none
module tb_maintenance_state_controller;
  import msc_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned HOLD = 20; // Shortened switch hold count.
  logic       i_clk_sys, i_nrst, i_switch_n, i_cmd_reset, i_cmd_indep, i_cmd_exit, i_cmd_update;
  logic       i_cmd_valid, i_cmd_is_set, i_priv_manager, i_act_valid, i_act_uses_modem;
  logic       i_st_done, i_st_minor, i_st_severe, i_image_ok, i_dl_done, i_rx_valid, i_call_step;
  logic [7:0] i_act_code, i_rx_char;
  logic [2:0] o_state;
  logic       o_impaired, o_card_owns_modem, o_modem_hangup, o_modem_off, o_dial, o_send_msg;
  logic       o_monitor_en, o_act_allow, o_cmd_accept, o_cmd_reject, o_rx_to_host, o_rx_to_card;
  logic       o_flash_wr_en, o_selftest_run, saw_msg;
  int         err_count, tests_run;
  msc_maintenance_state_controller #(.HOLD_CYC(HOLD)) dut (.i_clk_sys, .i_nrst, .i_switch_n, .i_cmd_reset,
    .i_cmd_indep, .i_cmd_exit, .i_cmd_update, .i_cmd_valid, .i_cmd_is_set, .i_priv_manager, .i_act_valid,
    .i_act_code, .i_act_uses_modem, .i_rx_valid, .i_rx_char, .i_st_done, .i_st_minor, .i_st_severe,
    .i_image_ok, .i_dl_done, .i_call_step, .o_state, .o_impaired, .o_card_owns_modem, .o_modem_hangup,
    .o_modem_off, .o_dial, .o_send_msg, .o_monitor_en, .o_act_allow, .o_cmd_accept, .o_cmd_reject,
    .o_rx_to_host, .o_rx_to_card, .o_flash_wr_en, .o_selftest_run);
  msc_remote_model far (.i_clk(i_clk_sys), .i_in_panic(o_state == 3'h3), .o_call_step(i_call_step),
    .o_rx_valid(i_rx_valid), .o_rx_char(i_rx_char));
  // Free-running system clock.
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  // The message phase is short, so it is caught here rather than polled.
  always @(posedge i_clk_sys) if (o_send_msg === 1'b1) saw_msg <= 1'b1;
  task automatic tick;
    @(posedge i_clk_sys);
    #1;
  endtask : tick
  // One edge passes first, so a strobe never falls and rises again in one time step.
  task automatic pulse(ref logic s);
    tick;
    s = 1'b1;
    tick;
    s = 1'b0;
  endtask : pulse
  task automatic chk_state(input logic [2:0] exp);
    tests_run++;
    if (o_state !== exp) begin
      err_count++;
      $display("unexpected at %0t: state %h, wanted %h", $time, o_state, exp);
    end
  endtask : chk_state
  task automatic chk_flag(input logic got, input logic exp, input string what);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s is %b", $time, what, got);
    end
  endtask : chk_flag
  // Bounded wait; the caller judges the state reached.
  task automatic wait_state(input logic [2:0] exp, input int n);
    for (int i = 0; i < n && o_state !== exp; i++) tick;
  endtask : wait_state
  task automatic act(input logic [7:0] code, input logic um);
    i_act_code       = code;
    i_act_uses_modem = um;
    pulse(i_act_valid);
  endtask : act
  task automatic cmd(input logic is_set, input logic mgr);
    i_cmd_is_set   = is_set;
    i_priv_manager = mgr;
    pulse(i_cmd_valid);
  endtask : cmd
  task automatic st(input logic sev, input logic minor, input logic img);
    {i_st_severe, i_st_minor, i_image_ok} = {sev, minor, img};
    pulse(i_st_done);
  endtask : st
  // Self-test after power-up refuses everything, then a clean pass lands in normal.
  task automatic t_boot;
    chk_state(3'h0);
    chk_flag(o_selftest_run, 1'b1, "selftest");
    cmd(1'b0, 1'b1);
    chk_flag(o_cmd_reject, 1'b1, "reject");
    act(8'h10, 1'b0);
    chk_flag(o_act_allow, 1'b0, "allow");
    st(1'b0, 1'b0, 1'b1);
    chk_state(3'h1);
    chk_flag(o_monitor_en, 1'b1, "monitor");
    act(8'h10, 1'b1);
    chk_flag(o_act_allow, 1'b1, "allow");
  endtask : t_boot
  // Each self-test outcome from a reset command: severe, minor, bad image.
  task automatic t_outcomes;
    pulse(i_cmd_reset);
    chk_state(3'h0);
    st(1'b1, 1'b0, 1'b1);
    chk_state(3'h5);
    chk_flag(o_modem_off, 1'b1, "modem off");
    chk_flag(o_monitor_en, 1'b0, "monitor");
    pulse(i_cmd_reset);
    st(1'b0, 1'b1, 1'b1);
    chk_state(3'h1);
    chk_flag(o_impaired, 1'b1, "impaired");
    pulse(i_cmd_reset);
    st(1'b0, 1'b0, 1'b0);
    chk_state(3'h4);
    chk_flag(o_flash_wr_en, 1'b1, "flash");
    cmd(1'b0, 1'b1);
    chk_flag(o_cmd_reject, 1'b1, "reject");
    pulse(i_dl_done);
    st(1'b0, 1'b0, 1'b1);
    chk_flag(o_impaired, 1'b0, "impaired");
    pulse(i_cmd_update);
    chk_state(3'h4);
    pulse(i_dl_done);
    st(1'b0, 1'b0, 1'b1);
  endtask : t_outcomes
  // An interrupted escape run must not count; three in a row take the modem.
  task automatic t_escape;
    logic [7:0] seq [5] = '{8'h03, 8'h03, 8'h41, 8'h03, 8'h03};
    far.send_char(8'h41);
    chk_flag(o_rx_to_host, 1'b1, "to host");
    foreach (seq[i]) far.send_char(seq[i]);
    chk_state(3'h1);
    far.send_char(CHAR_CTRL_C);
    chk_state(3'h2);
    chk_flag(o_card_owns_modem, 1'b1, "owns modem");
    far.send_char(8'h41);
    chk_flag(o_rx_to_card, 1'b1, "to card");
    pulse(i_cmd_exit);
    chk_state(3'h1);
    chk_flag(o_modem_hangup, 1'b1, "hangup");
    act(ACT_INDEP, 1'b0);
    chk_state(3'h2);
    pulse(i_cmd_exit);
    pulse(i_cmd_indep);
    chk_state(3'h2);
  endtask : t_escape
  // Panic call from the given home state, with the line answering after dly cycles.
  task automatic t_panic(input logic [7:0] code, input int dly, input logic [2:0] home);
    far.delay = dly;
    saw_msg   = 1'b0;
    act(code, 1'b0);
    chk_state(3'h3);
    chk_flag(o_dial, 1'b1, "dial");
    act(8'h10, 1'b1);
    chk_flag(o_act_allow, 1'b0, "allow");
    act(8'h10, 1'b0);
    chk_flag(o_act_allow, 1'b1, "allow");
    wait_state(home, 60);
    chk_state(home);
    chk_flag(o_modem_hangup, 1'b1, "hangup");
    chk_flag(saw_msg, 1'b1, "message");
  endtask : t_panic
  // Set commands need manager level; queries pass at user level.
  task automatic t_priv;
    cmd(1'b1, 1'b0);
    chk_flag(o_cmd_reject, 1'b1, "reject");
    cmd(1'b1, 1'b1);
    chk_flag(o_cmd_accept, 1'b1, "accept");
    cmd(1'b0, 1'b0);
    chk_flag(o_cmd_accept, 1'b1, "accept");
  endtask : t_priv
  // A short press is ignored; holding past the count restarts self-test.
  task automatic t_press;
    i_switch_n = 1'b0;
    repeat (HOLD / 2) tick;
    i_switch_n = 1'b1;
    repeat (5) tick;
    chk_state(3'h1);
    i_switch_n = 1'b0;
    wait_state(3'h0, HOLD + 10);
    chk_state(3'h0);
    i_switch_n = 1'b1;
    st(1'b0, 1'b0, 1'b1);
  endtask : t_press
  task automatic conclude;
    $display("Checks run: %0d, mismatches: %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude
  // Main sequence: reset for six cycles, then every scenario in turn.
  initial begin
    {i_cmd_reset, i_cmd_indep, i_cmd_exit, i_cmd_update, i_cmd_valid, i_cmd_is_set} = '0;
    {i_priv_manager, i_act_valid, i_act_uses_modem, i_st_done, i_st_minor, i_st_severe, i_dl_done} = '0;
    {i_nrst, i_switch_n, i_image_ok, i_act_code} = {3'b011, 8'h00};
    {err_count, tests_run, saw_msg} = '0;
    repeat (6) @(posedge i_clk_sys);
    #1;
    i_nrst = 1'b1;
    t_boot;
    t_outcomes;
    t_priv;
    t_panic(ACT_PANIC_A, 0, 3'h1);
    t_escape;
    t_panic(ACT_PANIC_B, 4, 3'h2);
    pulse(i_cmd_exit);
    t_press;
    conclude;
  end
  // Watchdog well beyond the roughly 150 cycles the scenarios need.
  initial begin
    repeat (5000) @(posedge i_clk_sys);
    err_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    conclude;
  end
endmodule : tb_maintenance_state_controller
`default_nettype wire

// File: design/msc_maintenance_state_controller.sv
// Purpose: Operating-state sequencer and modem arbiter for the maintenance card.
// Assumes: Firmware and line logic provide one-cycle pulses; the reset switch is a raw pin.
// Notes: Impaired is a flag on top of normal or independent, giving seven visible states.
`default_nettype none
module msc_maintenance_state_controller #(
  parameter int unsigned HOLD_CYC = msc_pkg::HOLD_CYCLES   // Switch hold count, shortenable.
) (
  input  wire logic              i_clk_sys,       // System clock.
  input  wire logic              i_nrst,          // Asynchronous reset, active low; acts as power-up.
  input  wire logic              i_switch_n,      // Reset switch pin, low while pressed.
  input  wire logic              i_cmd_reset,     // Board reset command pulse.
  input  wire logic              i_cmd_indep,     // Independent command pulse.
  input  wire logic              i_cmd_exit,      // Exit command pulse.
  input  wire logic              i_cmd_update,    // Firmware update request pulse.
  input  wire logic              i_cmd_valid,     // Command presented for execution.
  input  wire logic              i_cmd_is_set,    // Command changes parameters.
  input  wire logic              i_priv_manager,  // Caller holds manager level.
  input  wire logic              i_act_valid,     // Action execution pulse.
  input  wire logic [7:0]        i_act_code,      // Action code.
  input  wire logic              i_act_uses_modem,// Action would use the modem.
  input  wire logic              i_rx_valid,      // Remote character pulse.
  input  wire logic [7:0]        i_rx_char,       // Remote character.
  input  wire logic              i_st_done,       // Self-test finished pulse.
  input  wire logic              i_st_minor,      // Less severe error found.
  input  wire logic              i_st_severe,     // Severe error found.
  input  wire logic              i_image_ok,      // Firmware image valid and current.
  input  wire logic              i_dl_done,       // Download completed pulse.
  input  wire logic              i_call_step,     // Current panic call phase finished pulse.
  output logic [2:0]             o_state,         // Current state code.
  output logic                   o_impaired,      // Impaired flag.
  output logic                   o_card_owns_modem,// Card owns the modem.
  output logic                   o_modem_hangup,  // Hang-up pulse.
  output logic                   o_modem_off,     // Modem powered down.
  output logic                   o_dial,          // Dial phase.
  output logic                   o_send_msg,      // Panic message phase.
  output logic                   o_monitor_en,    // Event monitoring active.
  output logic                   o_act_allow,     // Current action allowed.
  output logic                   o_cmd_accept,    // Command accepted pulse.
  output logic                   o_cmd_reject,    // Command refused pulse.
  output logic                   o_rx_to_host,    // Remote character forwarded to host.
  output logic                   o_rx_to_card,    // Remote character taken by card.
  output logic                   o_flash_wr_en,   // Flash writing enabled.
  output logic                   o_selftest_run   // Self-test running.
);
  import msc_pkg::*;

  // All state in one packed struct.
  typedef struct packed {
    logic             sw_s1;      // Synchroniser first stage.
    logic             sw_s2;      // Synchroniser second stage.
    logic [31:0]      hold_cnt;   // Press duration counter.
    logic             hold_fired; // Long press already acted on.
    msc_state_e       state;      // Operating state.
    msc_state_e       ret_state;  // State to resume after panic.
    msc_phase_e       phase;      // Panic call phase.
    logic             impaired;   // Impaired flag.
    logic             chk_image;  // Image check flag; reset clears it and no logic sets or reads it.
    logic [1:0]       esc_cnt;    // Consecutive Ctrl-C count.
    logic [2:0]       o_state;
    logic             o_impaired;
    logic             o_own;
    logic             o_hangup;
    logic             o_off;
    logic             o_dial;
    logic             o_msg;
    logic             o_mon;
    logic             o_allow;
    logic             o_acc;
    logic             o_rej;
    logic             o_host;
    logic             o_card;
    logic             o_flash;
    logic             o_st;
  } msc_regs_s;

  msc_regs_s r_reg;   // Registered state.
  msc_regs_s r_next;  // Next state.

  // True when an action code starts a panic call.
  function automatic logic is_panic(input logic [7:0] code);
    is_panic = (code == ACT_PANIC_A) || (code == ACT_PANIC_B);
  endfunction : is_panic

  // True when the state runs monitoring and actions.
  function automatic logic is_live(input msc_state_e s);
    is_live = (s == ST_NORMAL) || (s == ST_INDEP) || (s == ST_PANIC);
  endfunction : is_live

  // Next-state logic for the whole controller.
  always_comb begin
    logic long_press;
    logic esc_hit;
    logic act_go;
    long_press = 1'b0;
    esc_hit    = 1'b0;
    act_go     = 1'b0;
    r_next = r_reg;
    r_next.sw_s1    = ~i_switch_n;
    r_next.sw_s2    = r_reg.sw_s1;
    r_next.o_hangup = 1'b0;
    r_next.o_acc    = 1'b0;
    r_next.o_rej    = 1'b0;
    r_next.o_host   = 1'b0;
    r_next.o_card   = 1'b0;

    // Long press counter; fires once per press so a held switch does not loop self-test.
    if (r_reg.sw_s2) begin
      if (r_reg.hold_cnt < HOLD_CYC) begin
        r_next.hold_cnt = r_reg.hold_cnt + 32'd1;
      end else if (!r_reg.hold_fired) begin
        long_press = 1'b1;  // RULE_02
        r_next.hold_fired = 1'b1;
      end
    end else begin
      r_next.hold_cnt   = HOLD_RESET;
      r_next.hold_fired = 1'b0;
    end

    // Escape detector counts consecutive Ctrl-C from the line, in normal state only.
    if (i_rx_valid && r_reg.state == ST_NORMAL) begin
      if (i_rx_char == CHAR_CTRL_C) begin
        if (r_reg.esc_cnt == ESC_COUNT - 2'd1) begin
          esc_hit = 1'b1;  // RULE_08
          r_next.esc_cnt = 2'h0;
        end else begin
          r_next.esc_cnt = r_reg.esc_cnt + 2'd1;
        end
      end else begin
        r_next.esc_cnt = 2'h0;  // RULE_20
      end
    end

    // Remote characters go to host in normal, to the card in independent.
    if (i_rx_valid) begin
      r_next.o_host = (r_reg.state == ST_NORMAL);  // RULE_07
      r_next.o_card = (r_reg.state == ST_INDEP);   // RULE_10
    end

    // Actions run only in live states; panic blocks modem users.
    act_go = i_act_valid && is_live(r_reg.state) &&
             !(r_reg.state == ST_PANIC && i_act_uses_modem);  // RULE_13
    r_next.o_allow = act_go;  // RULE_06 RULE_09

    // Commands: user level may only query; nothing is taken outside normal or independent.
    if (i_cmd_valid) begin
      if ((r_reg.state == ST_NORMAL || r_reg.state == ST_INDEP) &&
          (i_priv_manager || !i_cmd_is_set)) begin  // RULE_16
        r_next.o_acc = 1'b1;  // RULE_06
      end else begin
        r_next.o_rej = 1'b1;  // RULE_03 RULE_15
      end
    end

    // Operating state sequencing.
    unique case (r_reg.state)
      ST_SELFTEST: begin
        if (i_st_done) begin
          if (i_st_severe) begin
            r_next.state = ST_DISABLED;  // RULE_05
          end else if (!i_image_ok) begin
            r_next.state = ST_DOWNLOAD;  // RULE_14
          end else begin
            r_next.state    = ST_NORMAL;  // RULE_04
            r_next.impaired = i_st_minor; // RULE_18
          end
        end
      end
      ST_NORMAL: begin
        if (act_go && is_panic(i_act_code)) begin
          r_next.state     = ST_PANIC;  // RULE_11
          r_next.ret_state = ST_NORMAL;
          r_next.phase     = PH_DIAL;
        end else if (esc_hit || i_cmd_indep || (act_go && i_act_code == ACT_INDEP)) begin
          r_next.state = ST_INDEP;  // RULE_08
        end else if (i_cmd_update) begin
          r_next.state = ST_DOWNLOAD;  // RULE_14
        end
      end
      ST_INDEP: begin
        if (act_go && is_panic(i_act_code)) begin
          r_next.state     = ST_PANIC;  // RULE_11
          r_next.ret_state = ST_INDEP;
          r_next.phase     = PH_DIAL;
        end else if (i_cmd_exit) begin
          r_next.state    = ST_NORMAL;  // RULE_17
          r_next.o_hangup = 1'b1;
        end
      end
      ST_PANIC: begin
        // Dial, connect, message, hang up, then resume.
        if (i_call_step) begin
          unique case (r_reg.phase)
            PH_DIAL:    r_next.phase = PH_CONNECT;
            PH_CONNECT: r_next.phase = PH_MSG;
            PH_MSG:     r_next.phase = PH_HANGUP;
            PH_HANGUP: begin
              r_next.phase    = PH_IDLE;
              r_next.o_hangup = 1'b1;
              r_next.state    = r_reg.ret_state;  // RULE_12
            end
            default:    r_next.phase = PH_DIAL;
          endcase
        end
      end
      ST_DOWNLOAD: begin
        if (i_dl_done) begin
          r_next.state = ST_SELFTEST;  // RULE_14
        end
      end
      ST_DISABLED: begin
        r_next.state = ST_DISABLED;  // RULE_19
      end
      default: begin
        r_next.state = ST_SELFTEST;  // RULE_01
      end
    endcase

    // Reset command and long press win over every other state move.
    if (long_press || i_cmd_reset) begin
      r_next.state    = ST_SELFTEST;  // RULE_02
      r_next.phase    = PH_IDLE;
      r_next.impaired = 1'b0;
      r_next.esc_cnt  = 2'h0;
    end

    // Registered outputs follow the next state.
    r_next.o_state    = r_next.state;
    r_next.o_impaired = r_next.impaired;
    r_next.o_own      = (r_next.state == ST_INDEP) || (r_next.state == ST_PANIC);  // RULE_09 RULE_12
    r_next.o_off      = (r_next.state == ST_DISABLED);  // RULE_19
    r_next.o_dial     = (r_next.state == ST_PANIC) && (r_next.phase == PH_DIAL);
    r_next.o_msg      = (r_next.state == ST_PANIC) && (r_next.phase == PH_MSG);
    r_next.o_mon      = is_live(r_next.state);  // RULE_06
    r_next.o_flash    = (r_next.state == ST_DOWNLOAD);  // RULE_15
    r_next.o_st       = (r_next.state == ST_SELFTEST);  // RULE_03
  end

  // State register; reset acts as power-up and lands in self-test.
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      r_reg       <= '0;
      r_reg.state <= ST_SELFTEST;  // RULE_02
      r_reg.o_st  <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_state           = r_reg.o_state;
  assign o_impaired        = r_reg.o_impaired;
  assign o_card_owns_modem = r_reg.o_own;
  assign o_modem_hangup    = r_reg.o_hangup;
  assign o_modem_off       = r_reg.o_off;
  assign o_dial            = r_reg.o_dial;
  assign o_send_msg        = r_reg.o_msg;
  assign o_monitor_en      = r_reg.o_mon;
  assign o_act_allow       = r_reg.o_allow;
  assign o_cmd_accept      = r_reg.o_acc;
  assign o_cmd_reject      = r_reg.o_rej;
  assign o_rx_to_host      = r_reg.o_host;
  assign o_rx_to_card      = r_reg.o_card;
  assign o_flash_wr_en     = r_reg.o_flash;
  assign o_selftest_run    = r_reg.o_st;

  // Three Ctrl-C in a row in normal state.
  sequence s_three_ctrl_c;
    (i_rx_valid && i_rx_char == CHAR_CTRL_C && r_reg.state == ST_NORMAL && r_reg.esc_cnt == 2'd2);
  endsequence

  // A long press fires this cycle; checks exclude it because it overrides every other move.
  logic long_due;  // Long press due now.
  assign long_due = r_reg.sw_s2 && (r_reg.hold_cnt >= HOLD_CYC) && !r_reg.hold_fired;

  // Assertions.
  a_state_legal: assert property (@(posedge i_clk_sys) disable iff (!i_nrst) // RULE_01
    r_reg.state inside {ST_SELFTEST, ST_NORMAL, ST_INDEP, ST_PANIC, ST_DOWNLOAD, ST_DISABLED})
    else $error("Illegal state.");
  a_reset_cmd: assert property (@(posedge i_clk_sys) disable iff (!i_nrst) // RULE_02
    i_cmd_reset |=> r_reg.state == ST_SELFTEST)
    else $error("Reset command ignored.");
  a_selftest_quiet: assert property (@(posedge i_clk_sys) disable iff (!i_nrst) // RULE_03
    (r_reg.state == ST_SELFTEST && i_cmd_valid) |=> o_cmd_reject && !o_cmd_accept)
    else $error("Command taken in self-test.");
  a_pass_normal: assert property (@(posedge i_clk_sys) disable iff (!i_nrst) // RULE_04
    (r_reg.state == ST_SELFTEST && i_st_done && !i_st_severe && i_image_ok && !i_cmd_reset && !long_due)
    |=> r_reg.state == ST_NORMAL && r_reg.impaired == $past(i_st_minor))
    else $error("Self-test pass not normal.");
  a_fail_disabled: assert property (@(posedge i_clk_sys) disable iff (!i_nrst) // RULE_05
    (r_reg.state == ST_SELFTEST && i_st_done && i_st_severe && !i_cmd_reset && !long_due)
    |=> r_reg.state == ST_DISABLED)
    else $error("Severe fail not disabled.");
  a_host_forward: assert property (@(posedge i_clk_sys) disable iff (!i_nrst) // RULE_07
    (i_rx_valid && r_reg.state == ST_NORMAL) |=> o_rx_to_host && !o_rx_to_card)
    else $error("Remote char not forwarded.");
  a_escape_indep: assert property (@(posedge i_clk_sys) disable iff (!i_nrst) // RULE_08
    (s_three_ctrl_c and (!i_cmd_reset && !long_due && !(i_act_valid && is_panic(i_act_code))))
    |=> r_reg.state == ST_INDEP && o_card_owns_modem)
    else $error("Escape missed.");
  a_panic_block: assert property (@(posedge i_clk_sys) disable iff (!i_nrst) // RULE_13
    (r_reg.state == ST_PANIC && i_act_valid && i_act_uses_modem) |=> !o_act_allow)
    else $error("Interfering action allowed.");
  a_exit_hangup: assert property (@(posedge i_clk_sys) disable iff (!i_nrst) // RULE_17
    (r_reg.state == ST_INDEP && i_cmd_exit && !i_cmd_reset && !long_due &&
     !(i_act_valid && is_panic(i_act_code)))
    |=> o_modem_hangup && r_reg.state == ST_NORMAL)
    else $error("Exit not handled.");
  a_user_query: assert property (@(posedge i_clk_sys) disable iff (!i_nrst) // RULE_16
    (i_cmd_valid && i_cmd_is_set && !i_priv_manager) |=> !o_cmd_accept)
    else $error("User set accepted.");
  a_disabled_off: assert property (@(posedge i_clk_sys) disable iff (!i_nrst) // RULE_19
    (r_reg.state == ST_DISABLED && !i_cmd_reset && !long_due) |=> o_modem_off)
    else $error("Disabled modem on.");
  a_panic_return: assert property (@(posedge i_clk_sys) disable iff (!i_nrst) // RULE_12
    (r_reg.state == ST_PANIC && r_reg.phase == PH_HANGUP && i_call_step && !i_cmd_reset && !long_due)
    |=> r_reg.state == $past(r_reg.ret_state) && o_modem_hangup)
    else $error("Panic return wrong.");
endmodule : msc_maintenance_state_controller
`default_nettype wire

// File: inc/msc_pkg.sv
// Purpose: Constants and types for the maintenance card operating-state controller.
// Assumes: 100 MHz system clock, one clock domain.
// Notes: Holds timing, state codes and character codes shared by the design.
//
// Functional notes
// (RULE_01) Always exactly one of seven states.
// (RULE_02) Self-test on power-up, reset command, long press.
// (RULE_03) Self-test offers no user capabilities.
// (RULE_04) Self-test pass moves to normal.
// (RULE_05) Self-test fail goes disabled or impaired.
// (RULE_06) Normal monitors events, runs actions, answers commands.
// (RULE_07) Normal passes remote commands to host.
// (RULE_08) Independent on action 89, command, triple Ctrl-C.
// (RULE_09) Independent owns modem, keeps monitoring and actions.
// (RULE_10) Independent accepts remote commands directly.
// (RULE_11) Panic dialout on action 51 or 52.
// (RULE_12) Panic call sequence, then return to prior state.
// (RULE_13) Panic suppresses actions interfering with call.
// (RULE_14) Download on bad image or update request.
// (RULE_15) Download offers nothing else, writes flash.
// (RULE_16) User level queries only; manager does all.
// (RULE_17) Exit in independent: normal, hang up modem.
// (RULE_18) Minor self-test error marks impaired, keeps running.
// (RULE_19) Disabled shuts card and modem down.
// (RULE_20) Non Ctrl-C character clears escape count.
`default_nettype none
package msc_pkg;
  // Reset switch hold time in milliseconds and its cycle count at 100 MHz.
  localparam int unsigned HOLD_TIME_MS   = 3500;
  localparam int unsigned CLK_HZ         = 100_000_000;
  localparam int unsigned HOLD_CYCLES    = (HOLD_TIME_MS * (CLK_HZ / 1000));
  // Character and action codes.
  localparam logic [7:0]  CHAR_CTRL_C    = 8'h03;
  localparam logic [7:0]  ACT_INDEP      = 8'd89;
  localparam logic [7:0]  ACT_PANIC_A    = 8'd51;
  localparam logic [7:0]  ACT_PANIC_B    = 8'd52;
  localparam logic [1:0]  ESC_COUNT      = 2'h3;
  // Operating states.
  typedef enum logic [2:0] {
    ST_SELFTEST = 3'b000,
    ST_NORMAL   = 3'b001,
    ST_INDEP    = 3'b010,
    ST_PANIC    = 3'b011,
    ST_DOWNLOAD = 3'b100,
    ST_DISABLED = 3'b101
  } msc_state_e;
  // Panic call phases.
  typedef enum logic [2:0] {
    PH_IDLE    = 3'b000,
    PH_DIAL    = 3'b001,
    PH_CONNECT = 3'b010,
    PH_MSG     = 3'b011,
    PH_HANGUP  = 3'b100
  } msc_phase_e;
  localparam logic [31:0] HOLD_RESET     = 32'h0;
endpackage : msc_pkg
`default_nettype wire
